// >>> verilog/i2c_register_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "i2c_port_defines.svh"
module i2c_register_port
	import i2c_port_pkg::*;
#(
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// strap
	input wire logic address_select_pin,
	// two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// register writes toward the core
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [7:0] wr_addr,
	output logic [15:0] wr_data,
	// register reads from the core
	output logic [7:0] rd_addr,
	input wire logic [15:0] rd_data,
	// status
	output logic busy
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	port_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] ptr_reg;
	logic byte_half_reg;
	logic [7:0] high_data_byte_reg;
	logic ack_phase_reg;
	logic ack_drive_reg;
	logic tx_drive_reg;
	logic [7:0] tx_byte_reg;
	logic master_nack_reg;
	logic address_low_bit_reg;
	logic fifo_in_ready;
	logic fifo_in_valid;
	reg_write_t fifo_in;
	reg_write_t fifo_out;
	logic byte_done;
	logic addr_match;
	logic ack_done_reg;
	logic byte_take_reg;
	logic ptr_load_reg;
	logic byte_take_q_reg;
	logic ack_ok_reg;
	logic rd_start_reg;

	// two flops per pin before any logic looks at it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_sync_reg <= `SYNC_RESET;
			sda_sync_reg <= `SYNC_RESET;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end

	assign scl_rise = scl_sync_reg[1] && !scl_d_reg;
	assign scl_fall = !scl_sync_reg[1] && scl_d_reg;
	// edges only while clock stays high, so data during clock high is control
	assign start_det = scl_sync_reg[1] && scl_d_reg
		&& sda_d_reg && !sda_sync_reg[1];
	assign stop_det = scl_sync_reg[1] && scl_d_reg
		&& !sda_d_reg && sda_sync_reg[1];

	// strap caught by a clocked process, never under reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			address_low_bit_reg <= 1'b0;
		else
			address_low_bit_reg <= address_select_pin;
	end

	// decoded on the eighth rise: the seven address bits sit in the low end
	assign addr_match = shift_reg[6:0]
		== {`ADDR_FIXED_BITS, address_low_bit_reg};
	// eighth data bit sampled on this rise
	assign byte_done = scl_rise && !ack_phase_reg
		&& bit_cnt_reg == `BIT_COUNT_LAST;

	// bit counter and receive shifter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
		end else if (start_det || stop_det) begin
			bit_cnt_reg <= 4'h0;
		end else if (scl_rise && !ack_phase_reg) begin
			shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
			if (bit_cnt_reg == `BIT_COUNT_LAST)
				bit_cnt_reg <= 4'h0;
			else
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// ninth clock: rise samples master answer, fall ends the slot
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ack_phase_reg <= 1'b0;
		else if (start_det || stop_det)
			ack_phase_reg <= 1'b0;
		else if (byte_done)
			ack_phase_reg <= 1'b1;
		else if (scl_fall && ack_phase_reg && ack_done_reg)
			ack_phase_reg <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ack_done_reg <= 1'b0;
		else if (start_det || stop_det || !ack_phase_reg)
			ack_done_reg <= 1'b0;
		else if (scl_rise)
			ack_done_reg <= 1'b1;
	end

	// transaction state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
		end else if (start_det) begin
			state_reg <= ST_ADDR;
		end else if (byte_done) begin
			unique case (state_reg)
				ST_ADDR: begin
					if (!addr_match)
						state_reg <= ST_IGNORE;
					else if (sda_sync_reg[1])
						state_reg <= ST_RDATA;
					else
						state_reg <= ST_PTR;
				end
				ST_PTR: state_reg <= ST_WDATA;
				ST_WDATA: state_reg <= ST_WDATA;
				ST_RDATA: state_reg <= ST_RDATA;
				ST_IDLE, ST_IGNORE: state_reg <= state_reg;
				default: state_reg <= ST_IDLE;
			endcase
		end else if (scl_rise && ack_phase_reg && state_reg == ST_RDATA
			&& sda_sync_reg[1]) begin
			state_reg <= ST_IGNORE;
		end
	end

	// note: byte_done sees shift_reg before the eighth bit lands, so the
	// decode uses the assembled byte one cycle later via byte_take
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			byte_take_reg <= 1'b0;
		else
			byte_take_reg <= byte_done && !start_det && !stop_det;
	end

	// pointer, half-group tracking and write hand-off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_reg <= `PTR_RESET;
			byte_half_reg <= 1'b0;
			high_data_byte_reg <= 8'h00;
		end else if (start_det) begin
			byte_half_reg <= 1'b0;
		end else if (byte_take_reg && state_reg == ST_WDATA
			&& !ptr_load_reg) begin
			byte_half_reg <= !byte_half_reg;
			if (!byte_half_reg)
				high_data_byte_reg <= shift_reg;
			else
				ptr_reg <= ptr_reg + 8'h01;
		end else if (byte_take_reg && ptr_load_reg) begin
			ptr_reg <= shift_reg;
		end else if (scl_rise && ack_phase_reg && state_reg == ST_RDATA
			&& !sda_sync_reg[1] && !rd_start_reg) begin
			byte_half_reg <= !byte_half_reg;
			if (byte_half_reg)
				ptr_reg <= ptr_reg + 8'h01;
		end
	end

	// marks that the byte just taken is the pointer byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ptr_load_reg <= 1'b0;
		else if (byte_done)
			ptr_load_reg <= state_reg == ST_PTR;
		else if (byte_take_reg)
			ptr_load_reg <= 1'b0;
	end

	assign fifo_in_valid = byte_take_reg && state_reg == ST_WDATA
		&& !ptr_load_reg && byte_half_reg;
	assign fifo_in.reg_addr = ptr_reg;
	assign fifo_in.reg_data = {high_data_byte_reg, shift_reg};

	// device acknowledge drive during the ninth clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ack_drive_reg <= 1'b0;
		else if (start_det || stop_det)
			ack_drive_reg <= 1'b0;
		else if (scl_fall && ack_phase_reg && !ack_done_reg
			&& byte_take_q_reg && ack_ok_reg)
			ack_drive_reg <= 1'b1;
		else if (scl_fall && ack_done_reg)
			ack_drive_reg <= 1'b0;
	end

	// remember whether the byte just received deserves an acknowledge;
	// a full write buffer withholds it, and a word offered while full is dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			byte_take_q_reg <= 1'b0;
			ack_ok_reg <= 1'b0;
		end else if (start_det || stop_det || !ack_phase_reg) begin
			byte_take_q_reg <= 1'b0;
			ack_ok_reg <= 1'b0;
		end else if (byte_take_reg) begin
			byte_take_q_reg <= 1'b1;
			ack_ok_reg <= (state_reg == ST_PTR || state_reg == ST_RDATA
				|| (state_reg == ST_WDATA && fifo_in_ready))
				&& !(state_reg == ST_RDATA && !rd_start_reg);
		end
	end

	// address with read bit enters ST_RDATA and still needs its acknowledge
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rd_start_reg <= 1'b0;
		else if (byte_done)
			rd_start_reg <= state_reg == ST_ADDR;
	end

	// transmit shifter: load after acknowledge slot, shift on clock fall
	assign rd_addr = ptr_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_drive_reg <= 1'b0;
			tx_byte_reg <= 8'hFF;
		end else if (start_det || stop_det || state_reg != ST_RDATA) begin
			tx_drive_reg <= 1'b0;
		end else if (scl_fall && ack_phase_reg && ack_done_reg) begin
			tx_drive_reg <= 1'b1;
			tx_byte_reg <= byte_half_reg ? rd_data[7:0]
				: rd_data[15:8];
		end else if (scl_fall && ack_phase_reg && !ack_done_reg) begin
			tx_drive_reg <= 1'b0;
		end else if (scl_fall && !ack_phase_reg && tx_drive_reg) begin
			tx_byte_reg <= {tx_byte_reg[6:0], 1'b1};
			if (bit_cnt_reg == 4'h0)
				tx_drive_reg <= 1'b0;
		end
	end

	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = ack_drive_reg || (tx_drive_reg && !tx_byte_reg[7]);
	assign busy = state_reg != ST_IDLE;

	write_fifo #(
		.WIDTH($bits(reg_write_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fifo_out)
	);
	assign wr_addr = fifo_out.reg_addr;
	assign wr_data = fifo_out.reg_data;
endmodule
`default_nettype wire

// >>> verilog/i2c_port_defines.svh
`ifndef I2C_PORT_DEFINES_SVH
`define I2C_PORT_DEFINES_SVH
`define ADDR_FIXED_BITS 6'h0D
`define PTR_RESET 8'h00
`define BIT_COUNT_LAST 4'h7
`define FIFO_DEPTH 16
`define SYNC_RESET 2'h3
`endif

// >>> verilog/i2c_port_pkg.sv
package i2c_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_PTR = 3'h2,
		ST_WDATA = 3'h3,
		ST_RDATA = 3'h4,
		ST_IGNORE = 3'h5
	} port_state_t;
	typedef struct packed {
		logic [7:0] reg_addr;
		logic [15:0] reg_data;
	} reg_write_t;
endpackage

// >>> verilog/write_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module write_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
		&& (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty = wr_ptr_reg == rd_ptr_reg;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];
	always_ff @(posedge clk) begin
		if (in_valid && !full)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wr_ptr_reg <= '0;
		else if (in_valid && !full)
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rd_ptr_reg <= '0;
		else if (out_ready && !empty)
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
	end
endmodule
`default_nettype wire

// >>> tb/i2c_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_port_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// write port and status
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [7:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence seq_start;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	sequence seq_stop;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
		else $error("sda_out driven high");
	AST_HOLD_HIGH: assert property (scl_in [*4] |-> $stable(sda_oe))
		else $error("sda_oe moved while scl high");
	AST_DRIVE_LOW: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("sda_oe rose while scl high");
	AST_START_BUSY: assert property (seq_start |-> ##[1:8] busy)
		else $error("start not seen");
	AST_STOP_IDLE: assert property (seq_stop |-> ##[1:8] !busy)
		else $error("stop not seen");
	AST_IDLE_FREE: assert property (!busy && $past(!busy) |-> !sda_oe)
		else $error("sda driven while idle");
	AST_WR_HOLD: assert property (wr_valid && !wr_ready |=>
		wr_valid && $stable(wr_addr) && $stable(wr_data))
		else $error("write dropped before taken");
	AST_RESET_QUIET: assert property ($fell(rst) |-> !wr_valid && !busy)
		else $error("not quiet after reset");
endmodule
bind i2c_register_port i2c_port_props props (.clk(clk), .rst(rst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
	.wr_data(wr_data), .busy(busy));
`default_nettype wire

// >>> tb/i2c_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
	// link pins
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// low phase kept long: the port needs about 8 core clocks low
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic xfer(input logic b, output logic s);
		sda_pull = !b;
		#40;
		scl = 1'b1;
		#20;
		s = sda;
		#20;
		scl = 1'b0;
		#40;
	endtask
	// start is cond(0,1), stop is cond(1,0); clock stays high after stop
	task automatic cond(input logic a, input logic b);
		sda_pull = a;
		#40;
		scl = 1'b1;
		#20;
		sda_pull = b;
		#40;
		if (b) begin
			scl = 1'b0;
			#40;
		end
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			xfer(d[i], s);
		xfer(1'b1, s);
		ack = !s;
	endtask
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			xfer(1'b1, d[i]);
		xfer(!ack, s);
	endtask
endmodule
`default_nettype wire

// >>> tb/i2c_slave_register_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_port_test;
	import i2c_port_pkg::*;
	localparam logic [6:0] BASE = 7'h1A;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic strap = 1'b0;
	logic scl, pull, sda_line, sda_out, sda_oe, busy, hold;
	logic wr_valid, wr_ready;
	logic [7:0] wr_addr, rd_addr;
	logic [15:0] wr_data, rd_data, seed, rseed;
	logic [15:0] regs [256];
	reg_write_t exp_q [$];
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #4 clk = !clk;
	assign sda_line = !((sda_oe && !sda_out) || pull);
	i2c_register_port #(.FIFO_DEPTH(16)) dut (.clk(clk), .rst(rst),
		.address_select_pin(strap), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
	i2c_master_model master (.scl(scl), .sda_pull(pull), .sda(sda_line));
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// core side: random stalls, register file answers reads
	always @(negedge clk) begin
		rseed <= step(rseed);
		wr_ready <= !hold && rseed[0];
		rd_data <= regs[rd_addr];
	end
	task automatic take();
		reg_write_t e;
		e = exp_q.size() != 0 ? exp_q.pop_front() : 24'hFFFFFF;
		check({wr_addr, wr_data}, e);
		regs[e.reg_addr] = e.reg_data;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			wrap_up();
		end
		if (!rst && wr_valid === 1'b1 && wr_ready === 1'b1)
			take();
	end
	task automatic addr(input logic [6:0] a, input logic rw, input logic ok);
		logic k;
		// off-grid so link edges never meet core clock edges
		if (rw == 1'b0)
			#3;
		master.cond(1'b0, 1'b1);
		master.wr_byte({a, rw}, k);
		check(24'(k), 24'(ok));
	endtask
	task automatic stop();
		master.cond(1'b1, 1'b0);
		repeat (12) @(posedge clk);
		check(24'(busy), 24'h0);
	endtask
	task automatic write(input logic [6:0] a, input logic [7:0] p, input int n);
		logic k;
		logic ok;
		ok = a == {6'h0D, strap};
		addr(a, 1'b0, ok);
		master.wr_byte(p, k);
		check(24'(k), 24'(ok));
		for (int i = 0; i < n; i++) begin
			seed = step(seed);
			if (ok)
				exp_q.push_back({8'(p + i), seed});
			master.wr_byte(seed[15:8], k);
			check(24'(k), 24'(ok));
			master.wr_byte(seed[7:0], k);
			check(24'(k), 24'(ok));
		end
	endtask
	task automatic read(input logic [7:0] p, input int n);
		logic k;
		logic [15:0] d;
		while (exp_q.size() != 0)
			@(posedge clk);
		addr({6'h0D, strap}, 1'b0, 1'b1);
		master.wr_byte(p, k);
		check(24'(k), 24'h1);
		addr({6'h0D, strap}, 1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			master.rd_byte(1'b1, d[15:8]);
			master.rd_byte(i < n - 1, d[7:0]);
			check(24'(d), 24'(regs[8'(p + i)]));
		end
		stop();
	endtask
	initial begin
		logic k;
		logic [7:0] p;
		int n;
		hold = 1'b0;
		wr_ready = 1'b0;
		rd_data = 16'h0000;
		seed = 16'hC269;
		rseed = 16'hC269;
		for (int i = 0; i < 256; i++)
			regs[i] = {8'(i), 8'(~i)};
		repeat (5) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		repeat (6) @(posedge clk);
		write(BASE, 8'hFE, 3);
		stop();
		read(8'hFE, 3);
		$display("test write_read done");
		write(7'h1B, 8'h10, 1);
		stop();
		@(negedge clk) strap = 1'b1;
		write(BASE, 8'h20, 1);
		stop();
		write(7'h1B, 8'h30, 2);
		stop();
		read(8'h30, 2);
		@(negedge clk) strap = 1'b0;
		$display("test address done");
		hold = 1'b1;
		write(BASE, 8'h40, 16);
		master.wr_byte(8'hA5, k);
		check(24'(k), 24'h0);
		stop();
		hold = 1'b0;
		read(8'h40, 16);
		$display("test fifo done");
		for (int j = 0; j < 4; j++) begin
			seed = step(seed);
			p = seed[7:0];
			n = 1 + int'(seed[9:8]);
			write(BASE, p, n);
			stop();
			read(p, n);
		end
		$display("test random done");
		wrap_up();
	end
endmodule
`default_nettype wire
